// File: hw/ivm_vector_map.sv
/*
  Holds the reset and interrupt vector address generator, the vector
  table relocation control with its timed unlock, and the interrupt
  blocking that the unlock sequence imposes.
  Assumes requests come from flag logic on ref_clk, that the core
  pulses take_irq when it accepts the presented vector, and that the
  core control register writes arrive as a one-cycle strobe.
*/
`timescale 1ns/1ps
`include "ivm_consts.svh"

// Overview of operation
// - Reset fetch goes to word zero.
// - External pin requests at 0x0002 to 0x0006.
// - Pin-change requests in slots 0x0008 to 0x000E.
// - Watchdog time-out at 0x0010.
// - Second 8-bit timer at 0x0012 to 0x0016.
// - Wide timer requests at 0x0018 to 0x001E.
// - First 8-bit timer at 0x0020 to 0x0024.
// - Serial peripheral complete at 0x0026.
// - First serial port at 0x0028 to 0x002C.
// - Comparator through store-ready at 0x002E to 0x0036.
// - Second serial port at 0x0038 to 0x003C.
// - Programmed fuse moves reset to boot start.
// - Select bit adds boot start to vectors.
// - Fuse and select choose reset and table base.
// - Vector fetched only when interrupt is taken.
// - Unlock bit self-clears after four cycles.
// - Interrupts blocked during the unlock sequence.
module ivm_vector_map #(
  parameter ivm_pkg::ivm_addr_t BOOT_START = `IVM_BOOT_START
) (
  input  wire logic               ref_clk,                 // System clock, 50 MHz.
  input  wire logic               rst_b,                   // Asynchronous reset, active low.
  input  wire logic               reset_fetch,             // Core requests reset fetch.
  input  wire logic               boot_reset_target_fuse,  // 0 means programmed.
  input  wire ivm_pkg::ivm_req_t  irq_req,                 // Pending enabled requests.
  input  wire logic               global_irq_en,           // Core global interrupt flag.
  input  wire logic               ctrl_wr,                 // Control register write strobe.
  input  wire logic               ctrl_wr_select,          // Written select value.
  input  wire logic               ctrl_wr_unlock,          // Written unlock value.
  input  wire logic               take_irq,                // Core accepts the vector.
  input  wire logic               instr_done,              // Core retires an instruction.
  output logic                    irq_pending,             // Vector ready to be taken.
  output ivm_pkg::ivm_idx_t       irq_index,               // Source number being taken.
  output ivm_pkg::ivm_addr_t      fetch_addr,              // Address the core fetches.
  output logic                    fetch_valid,             // Fetch address is meaningful.
  output logic                    vector_table_select,     // Table relocated to boot.
  output logic                    vector_change_unlock     // Unlock window open.
);
  import ivm_pkg::*;

  typedef enum logic [1:0] {
    IVM_IDLE   = 2'b00,
    IVM_OPEN   = 2'b01,
    IVM_TRAIL  = 2'b11
  } ivm_lock_t;

  ivm_lock_t lock_r;
  logic [2:0] unlock_cnt_r;
  logic       sel_r;
  logic       block_irq;
  ivm_addr_t  reset_addr;
  ivm_addr_t  table_base;
  ivm_addr_t  addr_r;
  logic       valid_r;
  ivm_idx_t   idx_r;

  ivm_ctl_if ctl ();

  ivm_prio_enc u_enc (
    .ctl (ctl)
  );

  // Slots are two words wide, so an odd boot start would split every slot.
  if (BOOT_START[0] != 1'b0) begin : g_bad_boot
    $error("BOOT_START must be an even word address");
  end

  // The unlock window opens on a write with the unlock bit set and closes
  // after the fixed count or when a select write arrives.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_r       <= IVM_IDLE;
      unlock_cnt_r <= `IVM_CNT_ZERO;
    end else begin
      unique case (lock_r)
        IVM_IDLE: begin
          if (ctrl_wr && ctrl_wr_unlock) begin
            lock_r       <= IVM_OPEN;
            unlock_cnt_r <= `IVM_UNLOCK_CYCLES;
          end
        end
        IVM_OPEN: begin
          if (ctrl_wr && !ctrl_wr_unlock) begin
            lock_r <= IVM_TRAIL;
          end else if (unlock_cnt_r == `IVM_CNT_STEP) begin
            lock_r <= IVM_IDLE;
          end
          unlock_cnt_r <= unlock_cnt_r - `IVM_CNT_STEP;
        end
        IVM_TRAIL: begin
          if (instr_done) begin
            lock_r <= IVM_IDLE;
          end
        end
        // The unused code can only appear after an upset; fall back to idle.
        default: begin
          lock_r <= IVM_IDLE;
        end
      endcase
    end
  end

  // Select only changes on the second write of the timed sequence.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= 1'b0;
    end else if (lock_r == IVM_OPEN && ctrl_wr && !ctrl_wr_unlock) begin
      sel_r <= ctrl_wr_select;
    end
  end

  assign vector_change_unlock = (lock_r == IVM_OPEN);
  assign vector_table_select  = sel_r;

  // Blocking never touches the global flag; it only gates the requests.
  assign block_irq = (lock_r != IVM_IDLE) || (ctrl_wr && ctrl_wr_unlock);
  assign ctl.reqs  = (global_irq_en && !block_irq) ? irq_req : '0;

  assign reset_addr = boot_reset_target_fuse ? `IVM_RESET_ADDR : BOOT_START;
  assign table_base = sel_r ? (BOOT_START + `IVM_TABLE_BASE) : `IVM_TABLE_BASE;

  assign irq_pending = ctl.hit;
  assign irq_index   = ctl.idx;

  // Slot n sits at base plus two words per source number, which places every
  // source of the table in its documented order.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r  <= `IVM_RESET_ADDR;
      valid_r <= 1'b0;
      idx_r   <= '0;
    end else if (reset_fetch) begin
      addr_r  <= reset_addr;
      valid_r <= 1'b1;
    end else if (take_irq && ctl.hit) begin
      addr_r  <= table_base + (`IVM_SLOT_WORDS * ivm_addr_t'(ctl.idx));
      valid_r <= 1'b1;
      idx_r   <= ctl.idx;
    end else begin
      valid_r <= 1'b0;
    end
  end

  assign fetch_addr  = addr_r;
  assign fetch_valid = valid_r;

  AST_RESET_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reset_fetch |=> fetch_valid && fetch_addr == $past(reset_addr))
    else $error("reset fetch address wrong");
  AST_BOOT_RESET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reset_fetch && !boot_reset_target_fuse |=> fetch_addr == BOOT_START)
    else $error("boot reset address wrong");
  AST_VEC_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r |=>
      fetch_addr == 17'(`IVM_TABLE_BASE + `IVM_SLOT_WORDS * 17'($past(ctl.idx))))
    else $error("vector address wrong");
  AST_VEC_BOOT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && sel_r |=>
      fetch_addr >= BOOT_START + `IVM_TABLE_BASE)
    else $error("relocated vector below boot start");
  AST_NO_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && !take_irq |=> !fetch_valid)
    else $error("vector fetched without take");
  AST_UNLOCK_CLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(vector_change_unlock) |-> ##[1:4] !vector_change_unlock)
    else $error("unlock bit not cleared in time");
  AST_SEL_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !vector_change_unlock |=> $stable(vector_table_select))
    else $error("select changed without unlock");
  AST_BLOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    vector_change_unlock |-> !irq_pending)
    else $error("interrupt presented during unlock");
  AST_PRIO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irq_pending |-> ctl.reqs[irq_index] && ((ctl.reqs & ((30'h1 << irq_index) - 30'h1)) == '0))
    else $error("not the lowest pending request");

  // Fixed table points, checked against their own constants so that a drift
  // in the slot arithmetic shows up at a named source.
  AST_PCHG_LAST: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_PCHG3 |=>
      fetch_addr == `IVM_VEC_PCHG3)
    else $error("last pin-change slot wrong");
  AST_WDOG: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_WDOG |=>
      fetch_addr == `IVM_VEC_WDOG)
    else $error("watchdog slot wrong");
  AST_T2_OVF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_T2_OVF |=>
      fetch_addr == `IVM_VEC_T2_OVF)
    else $error("second timer overflow slot wrong");
  AST_WT_CAPT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_WT_CAPT |=>
      fetch_addr == `IVM_VEC_WT_CAPT)
    else $error("wide timer capture slot wrong");
  AST_T0_OVF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_T0_OVF |=>
      fetch_addr == `IVM_VEC_T0_OVF)
    else $error("first timer overflow slot wrong");
  AST_SPI: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_SPI |=>
      fetch_addr == `IVM_VEC_SPI)
    else $error("serial peripheral slot wrong");
  AST_U0_TX: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_U0_TX |=>
      fetch_addr == `IVM_VEC_U0_TX)
    else $error("first serial port slot wrong");
  AST_STORE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_STORE |=>
      fetch_addr == `IVM_VEC_STORE)
    else $error("store ready slot wrong");
  AST_U1_TX: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && !sel_r && ctl.idx == `IVM_IDX_U1_TX |=>
      fetch_addr == `IVM_VEC_U1_TX)
    else $error("second serial port slot wrong");

  // The relocated table keeps the same spacing, only shifted by boot start.
  AST_VEC_SHIFT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reset_fetch && take_irq && ctl.hit && sel_r |=>
      fetch_addr == 17'(BOOT_START + `IVM_TABLE_BASE + `IVM_SLOT_WORDS * 17'($past(ctl.idx))))
    else $error("relocated vector address wrong");
  AST_SEL_CLOSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    vector_change_unlock && ctrl_wr && !ctrl_wr_unlock |=> !vector_change_unlock)
    else $error("unlock not closed by select write");
  AST_TRAIL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    lock_r == IVM_TRAIL |-> !irq_pending)
    else $error("interrupt presented before next instruction");
  AST_GIE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !global_irq_en |-> !irq_pending)
    else $error("interrupt presented while disabled");
endmodule : ivm_vector_map

// File: hw/ivm_consts.svh
/*
  Holds the numeric constants of the vector address map: vector slots,
  reset target, table base and unlock window length.
  Assumes a word-addressed program space of up to 17 bits.
*/
`ifndef IVM_CONSTS_SVH
`define IVM_CONSTS_SVH
`define IVM_ADDR_W        17
`define IVM_NUM_SRC       30
`define IVM_RESET_ADDR    17'h00000
`define IVM_TABLE_BASE    17'h00002
`define IVM_SLOT_WORDS    17'h00002
`define IVM_UNLOCK_CYCLES 3'h4
`define IVM_BOOT_START    17'h1F000
`define IVM_CNT_ZERO      3'h0
`define IVM_CNT_STEP      3'h1
`define IVM_IDX_PCHG3     5'h06
`define IVM_VEC_PCHG3     17'h0000E
`define IVM_IDX_WDOG      5'h07
`define IVM_VEC_WDOG      17'h00010
`define IVM_IDX_T2_OVF    5'h0A
`define IVM_VEC_T2_OVF    17'h00016
`define IVM_IDX_WT_CAPT   5'h0B
`define IVM_VEC_WT_CAPT   17'h00018
`define IVM_IDX_T0_OVF    5'h11
`define IVM_VEC_T0_OVF    17'h00024
`define IVM_IDX_SPI       5'h12
`define IVM_VEC_SPI       17'h00026
`define IVM_IDX_U0_TX     5'h15
`define IVM_VEC_U0_TX     17'h0002C
`define IVM_IDX_STORE     5'h1A
`define IVM_VEC_STORE     17'h00036
`define IVM_IDX_U1_TX     5'h1D
`define IVM_VEC_U1_TX     17'h0003C
`endif

// File: hw/ivm_pkg.sv
/*
  Holds the types shared by the vector address map modules.
  Assumes ivm_consts.svh is on the include path.
*/
`include "ivm_consts.svh"
package ivm_pkg;
  typedef logic [`IVM_ADDR_W-1:0] ivm_addr_t;
  typedef logic [`IVM_NUM_SRC-1:0] ivm_req_t;
  typedef logic [4:0] ivm_idx_t;
endpackage : ivm_pkg

// File: hw/ivm_ctl_if.sv
/*
  Holds the interface between the top and the request priority encoder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ivm_ctl_if;
  import ivm_pkg::*;
  ivm_req_t reqs;   // Masked requests.
  logic     hit;    // Some request present.
  ivm_idx_t idx;    // Lowest numbered request.
  modport enc (input reqs, output hit, output idx);
  modport top (output reqs, input hit, input idx);
endinterface : ivm_ctl_if

// File: hw/ivm_prio_enc.sv
/*
  Holds the lowest-first priority encoder over the request lines.
  Assumes the requests arrive already gated and on the block clock.
*/
`timescale 1ns/1ps
module ivm_prio_enc (
  ivm_ctl_if.enc ctl  // Request and answer group.
);
  import ivm_pkg::*;
  always_comb begin
    ctl.hit = 1'b0;
    ctl.idx = '0;
    for (int i = `IVM_NUM_SRC - 1; i >= 0; i--) begin
      if (ctl.reqs[i]) begin
        ctl.hit = 1'b1;
        ctl.idx = 5'(i);
      end
    end
  end
endmodule : ivm_prio_enc

// File: test/ivm_core_model.sv
/*
  Core fetch model: takes offered vectors, retires instructions.
  Assumes the map block runs on the same clock.
*/
`timescale 1ns/1ps
module ivm_core_model (
  input  wire logic ref_clk,      // Clock.
  input  wire logic rst_b,        // Reset, active low.
  input  wire logic irq_pending,  // Vector on offer.
  input  wire logic stall,        // Hold off taking.
  input  wire logic eager,        // Take with nothing on offer.
  output logic      take_irq,     // Take pulse.
  output logic      instr_done    // Retire pulse.
);
  logic [1:0] cnt_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      take_irq <= 1'b0;
    end else begin
      take_irq <= !take_irq && (eager || (irq_pending && !stall));
    end
  end
  // One instruction retires every fourth cycle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r      <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      cnt_r      <= cnt_r + 2'h1;
      instr_done <= (cnt_r == 2'h3);
    end
  end
endmodule : ivm_core_model

// File: test/ivm_vector_map_test.sv
/*
  Self-checking bench for the vector address map.
  Assumes the hw files are compiled first.
*/
`timescale 1ns/1ps
`include "ivm_consts.svh"
module ivm_vector_map_test;
  import ivm_pkg::*;
  localparam ivm_addr_t BOOT = 17'h0E000;
  logic      ref_clk = 1'b0;
  logic      rst_b = 1'b0;
  logic      reset_fetch = 1'b0;
  logic      boot_reset_target_fuse = 1'b1;
  ivm_req_t  irq_req = '0;
  logic      global_irq_en = 1'b1;
  logic      ctrl_wr = 1'b0;
  logic      ctrl_wr_select = 1'b0;
  logic      ctrl_wr_unlock = 1'b0;
  logic      stall = 1'b0;
  logic      eager = 1'b0;
  logic      take_irq, instr_done, irq_pending, fetch_valid;
  logic      vector_table_select, vector_change_unlock;
  ivm_idx_t  irq_index;
  ivm_addr_t fetch_addr;
  int        fails = 0;
  int        samples_checked = 0;
  int        cycles = 0;
  always #10 ref_clk = ~ref_clk;
  ivm_vector_map #(.BOOT_START(BOOT)) uut (.ref_clk, .rst_b, .reset_fetch,
    .boot_reset_target_fuse, .irq_req, .global_irq_en, .ctrl_wr, .ctrl_wr_select,
    .ctrl_wr_unlock, .take_irq, .instr_done, .irq_pending, .irq_index, .fetch_addr,
    .fetch_valid, .vector_table_select, .vector_change_unlock);
  ivm_core_model core (.ref_clk, .rst_b, .irq_pending, .stall, .eager, .take_irq,
    .instr_done);
  task automatic chk_addr(string what, ivm_addr_t exp, ivm_addr_t got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_addr
  task automatic chk_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  function automatic ivm_addr_t exp_vec(logic s, int n);
    return (s ? BOOT : 17'h00000) + `IVM_TABLE_BASE + `IVM_SLOT_WORDS * ivm_addr_t'(n);
  endfunction : exp_vec
  task automatic final_report;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic wr(logic u, logic s);
    @(negedge ref_clk);
    ctrl_wr        = 1'b1;
    ctrl_wr_unlock = u;
    ctrl_wr_select = s;
    @(negedge ref_clk);
    ctrl_wr = 1'b0;
  endtask : wr
  task automatic rst_fetch(logic f);
    @(negedge ref_clk);
    boot_reset_target_fuse = f;
    reset_fetch            = 1'b1;
    @(negedge ref_clk);
    reset_fetch = 1'b0;
    chk_bit("fetch_valid", 1'b1, fetch_valid);
    chk_addr("reset", f ? `IVM_RESET_ADDR : BOOT, fetch_addr);
  endtask : rst_fetch
  // Lower sources stay quiet, higher ones are random, so source n must win.
  task automatic vec(logic s, int n);
    @(negedge ref_clk);
    stall   = 1'b1;
    irq_req = ivm_req_t'($urandom()) & ~((ivm_req_t'(1) << n) - 1) | (ivm_req_t'(1) << n);
    repeat ($urandom_range(3, 1)) @(negedge ref_clk);
    stall = 1'b0;
    for (int i = 0; i < 20 && fetch_valid !== 1'b1; i++) @(negedge ref_clk);
    chk_bit("fetch_valid", 1'b1, fetch_valid);
    chk_addr("vector", exp_vec(s, n), fetch_addr);
    chk_addr("index", ivm_addr_t'(n), ivm_addr_t'(irq_index));
    irq_req = '0;
  endtask : vec
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    void'($urandom(83));
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    rst_fetch(1'b1);
    rst_fetch(1'b0);
    $display("test reset done");
    for (int n = 0; n < 30; n++) vec(1'b0, n);
    $display("test table done");
    eager = 1'b1;
    repeat (3) begin
      @(negedge ref_clk);
      chk_bit("fetch_valid", 1'b0, fetch_valid);
    end
    eager = 1'b0;
    $display("test idle take done");
    wr(1'b1, 1'b0);
    irq_req = 30'h00000001;
    chk_bit("unlock", 1'b1, vector_change_unlock);
    @(negedge ref_clk);
    chk_bit("pending", 1'b0, irq_pending);
    irq_req = '0;
    repeat (5) @(negedge ref_clk);
    chk_bit("unlock", 1'b0, vector_change_unlock);
    wr(1'b0, 1'b1);
    chk_bit("select", 1'b0, vector_table_select);
    wr(1'b1, 1'b0);
    wr(1'b0, 1'b1);
    chk_bit("select", 1'b1, vector_table_select);
    chk_bit("unlock", 1'b0, vector_change_unlock);
    repeat (6) vec(1'b1, $urandom_range(29, 0));
    $display("test relocate done");
    @(negedge ref_clk);
    global_irq_en = 1'b0;
    irq_req       = ivm_req_t'($urandom()) | ivm_req_t'(1);
    repeat (3) begin
      @(negedge ref_clk);
      chk_bit("gated pending", 1'b0, irq_pending);
      chk_bit("gated fetch", 1'b0, fetch_valid);
    end
    irq_req       = '0;
    global_irq_en = 1'b1;
    rst_fetch(1'b1);
    rst_fetch(1'b0);
    $display("test gate and relocated reset done");
    final_report();
  end
endmodule : ivm_vector_map_test
